//--- wdt_pkg.sv
package wdt_pkg;
    localparam int WDT_BUS_AW = 8;
    // byte address on the bus is the register index times four
    localparam logic [7:0] WDT_IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] WDT_IDX_RELOAD_COUNT = 8'hFF;
    localparam logic [7:0] WDT_IDX_AUX_CONTROL = 8'h10;
    localparam logic [9:0] WDT_ADDR_POWER_CONTROL = {WDT_IDX_POWER_CONTROL, 2'b00};
    localparam logic [9:0] WDT_ADDR_RELOAD_COUNT = {WDT_IDX_RELOAD_COUNT, 2'b00};
    localparam logic [9:0] WDT_ADDR_AUX_CONTROL = {WDT_IDX_AUX_CONTROL, 2'b00};
    // field positions
    localparam int WDT_PC_IDLE_BIT = 0;
    localparam int WDT_PC_PDOWN_BIT = 1;
    localparam int WDT_PC_LOAD_EN_BIT = 4;
    localparam int WDT_AUX_ENABLE_BIT = 4;
    // reset values
    localparam logic [7:0] WDT_COUNT_RST = 8'h00;
    localparam logic [10:0] WDT_PRESC_RST = 11'h000;
    localparam logic [2:0] WDT_DIV6_RST = 3'h0;
    // timing
    localparam int WDT_CLK_MHZ = 100;
    localparam logic [2:0] WDT_DIV6_LAST = 3'h5;
    localparam logic [10:0] WDT_PRESC_LAST = 11'h7FF;
    localparam logic [13:0] WDT_STEP_LAST = 14'h2FFF;
    localparam int WDT_MACHINE_CYCLE_OSC = 12;
    localparam int WDT_PIN_PULSE_MC = 3;
    localparam logic [5:0] WDT_PIN_PULSE_CYC = 6'(WDT_PIN_PULSE_MC * WDT_MACHINE_CYCLE_OSC);
    localparam logic [31:0] WDT_UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        WDT_BUS_IDLE = 2'b00,
        WDT_BUS_ACK = 2'b01
    } wdt_bus_e;
endpackage

//--- wdt_timer_unit.sv
`timescale 1ns/1ps
// Operation
// R1 - eight-bit counter driven by eleven-bit prescaler
// R2 - prescaler fed at oscillator divided by six
// R3 - overflow issues internal system reset pulse
// R4 - overflow drives three machine-cycle pin pulse
// R5 - enable bit sticky, cleared only by reset
// R6 - counter write ignored without load enable
// R7 - successful load clears load enable automatically
// R8 - counter counts up from loaded value
// R9 - watchdog keeps running in idle mode
// R10 - power-down blocked and reads zero while enabled
// R11 - software reloads before interval expires
// R12 - software sets load enable, then writes counter
// R13 - any reset clears enable, load, counters
module wdt_timer_unit
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic sys_reset_r,
    output logic reset_pin_low_r,
    output logic idle_mode_r,
    output logic power_down_r
);
    import wdt_pkg::*;

    logic [2:0] div6_r;
    logic [10:0] presc_r;
    logic [7:0] count_r;
    logic enable_r;
    logic load_en_r;
    logic [5:0] pin_cnt_r;
    logic [31:0] rdata_nxt;
    wdt_bus_e bus_r;
    logic wr_go;
    logic rd_go;
    logic tick6;
    logic tick_count;
    logic overflow;
    logic any_rst;
    logic wr_pc;
    logic wr_rc;
    logic wr_aux;
    logic [13:0] step_cnt_r;

    function automatic logic lane0_ok(input logic [3:0] be);
        return be[0];
    endfunction

    // one wait cycle per access; request taken on the ack edge
    assign wr_go = avs_write && (bus_r == WDT_BUS_ACK);
    assign rd_go = avs_read && (bus_r == WDT_BUS_ACK);
    assign tick6 = (div6_r == WDT_DIV6_LAST);
    assign tick_count = tick6 && (presc_r == WDT_PRESC_LAST);
    assign overflow = enable_r && tick_count && (count_r == 8'hFF);
    // watchdog reset recurses into the block itself
    assign any_rst = rst || sys_reset_r;
    // byte lane 0 carries every 8-bit register
    assign wr_pc = wr_go && (avs_address == WDT_ADDR_POWER_CONTROL) && lane0_ok(avs_byteenable);
    assign wr_rc = wr_go && (avs_address == WDT_ADDR_RELOAD_COUNT) && lane0_ok(avs_byteenable);
    assign wr_aux = wr_go && (avs_address == WDT_ADDR_AUX_CONTROL) && lane0_ok(avs_byteenable);

    always_ff @(posedge clk)
    begin
        if (rst)
            bus_r <= WDT_BUS_IDLE;
        else if (bus_r == WDT_BUS_ACK)
            bus_r <= WDT_BUS_IDLE;
        else if (avs_read || avs_write)
            bus_r <= WDT_BUS_ACK;
    end

    // registered wait: high while idle, low only in the accepting cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else if (bus_r == WDT_BUS_ACK)
            avs_waitrequest <= 1'b1;
        else if (avs_read || avs_write)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // reference count of clocks per counter step, used by the period checks
    always_ff @(posedge clk)
    begin
        if (any_rst || !enable_r || tick_count)
            step_cnt_r <= 14'h0000;
        else
            step_cnt_r <= step_cnt_r + 14'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
            div6_r <= WDT_DIV6_RST; // R13
        else if (!enable_r)
            div6_r <= WDT_DIV6_RST;
        else if (tick6)
            div6_r <= WDT_DIV6_RST; // R2
        else
            div6_r <= div6_r + 3'h1;
    end

    // idle mode does not gate the prescaler
    always_ff @(posedge clk)
    begin
        if (any_rst)
            presc_r <= WDT_PRESC_RST; // R13
        else if (enable_r && tick6)
            presc_r <= presc_r + 11'h001; // R1 R9
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
            count_r <= WDT_COUNT_RST; // R13
        else if (wr_rc && load_en_r)
            count_r <= avs_writedata[7:0]; // R6 R8
        else if (enable_r && tick_count)
            count_r <= count_r + 8'h01; // R1 R8 R9
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
            enable_r <= 1'b0; // R13
        else if (wr_aux && avs_writedata[WDT_AUX_ENABLE_BIT])
            enable_r <= 1'b1; // R5
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
            load_en_r <= 1'b0; // R13
        else if (wr_rc && load_en_r)
            load_en_r <= 1'b0; // R7
        else if (wr_pc)
            load_en_r <= avs_writedata[WDT_PC_LOAD_EN_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            idle_mode_r <= 1'b0;
            power_down_r <= 1'b0;
        end
        else if (wr_pc)
        begin
            idle_mode_r <= avs_writedata[WDT_PC_IDLE_BIT];
            power_down_r <= avs_writedata[WDT_PC_PDOWN_BIT] && !enable_r; // R10
        end
        else if (enable_r)
            power_down_r <= 1'b0; // R10
    end

    // one-cycle internal reset pulse on overflow
    always_ff @(posedge clk)
    begin
        if (rst)
            sys_reset_r <= 1'b0;
        else
            sys_reset_r <= overflow; // R3
    end

    // pin pulse survives the internal reset it accompanies
    always_ff @(posedge clk)
    begin
        if (rst)
            pin_cnt_r <= 6'h00;
        else if (overflow)
            pin_cnt_r <= WDT_PIN_PULSE_CYC; // R4
        else if (pin_cnt_r != 6'h00)
            pin_cnt_r <= pin_cnt_r - 6'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            reset_pin_low_r <= 1'b0;
        else
            reset_pin_low_r <= overflow || (pin_cnt_r > 6'h01); // R4
    end

    always_comb
    begin
        rdata_nxt = WDT_UNMAPPED_DATA;
        if (avs_address == WDT_ADDR_POWER_CONTROL)
        begin
            rdata_nxt[WDT_PC_IDLE_BIT] = idle_mode_r;
            rdata_nxt[WDT_PC_PDOWN_BIT] = power_down_r && !enable_r; // R10
            rdata_nxt[WDT_PC_LOAD_EN_BIT] = load_en_r;
        end
        else if (avs_address == WDT_ADDR_RELOAD_COUNT)
            rdata_nxt[7:0] = count_r;
        else if (avs_address == WDT_ADDR_AUX_CONTROL)
            rdata_nxt[WDT_AUX_ENABLE_BIT] = enable_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            avs_readdata <= WDT_UNMAPPED_DATA;
        else if (avs_read && bus_r == WDT_BUS_IDLE)
            avs_readdata <= rdata_nxt;
    end

    AST_ENABLE_STICKY: assert property (@(posedge clk) disable iff (any_rst) // R5
        ($past(enable_r) && !$past(any_rst)) |-> enable_r)
        else $error("enable bit dropped without reset");
    AST_LOAD_IGNORED: assert property (@(posedge clk) disable iff (any_rst) // R6
        (wr_go && avs_address == WDT_ADDR_RELOAD_COUNT && !load_en_r && !tick_count)
        |=> $stable(count_r))
        else $error("counter loaded without load enable");
    AST_LOAD_CLEARS: assert property (@(posedge clk) disable iff (any_rst) // R7
        (wr_go && avs_address == WDT_ADDR_RELOAD_COUNT && avs_byteenable[0] && load_en_r)
        |=> !load_en_r && count_r == $past(avs_writedata[7:0]))
        else $error("load did not clear load enable");
    AST_COUNT_UP: assert property (@(posedge clk) disable iff (any_rst) // R8
        (enable_r && tick_count && !wr_go && count_r != 8'hFF) |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not advance by one");
    AST_OVF_RESET: assert property (@(posedge clk) disable iff (rst) // R3
        overflow |=> sys_reset_r ##1 (!enable_r && count_r == 8'h00))
        else $error("overflow did not reset the unit");
    AST_PIN_PULSE: assert property (@(posedge clk) disable iff (rst) // R4
        overflow |=> reset_pin_low_r [*8])
        else $error("pin pulse too short");
    AST_PDOWN_BLOCK: assert property (@(posedge clk) disable iff (any_rst) // R10
        enable_r |=> !power_down_r)
        else $error("power-down entered while enabled");
    AST_DIV6: assert property (@(posedge clk) disable iff (any_rst) // R2
        (enable_r && tick6) |=> div6_r == 3'h0 ##5 tick6)
        else $error("divide by six broken");
    AST_IDLE_RUN: assert property (@(posedge clk) disable iff (any_rst) // R9
        (enable_r && idle_mode_r && !tick6) |=> div6_r == $past(div6_r) + 3'h1)
        else $error("prescaler stopped in idle");

    // a counter step takes exactly six times the prescaler span
    AST_STEP_PERIOD: assert property (@(posedge clk) disable iff (any_rst) // R2
        tick_count |-> step_cnt_r == WDT_STEP_LAST)
        else $error("counter step period wrong");
    AST_STEP_BOUND: assert property (@(posedge clk) disable iff (any_rst) // R2
        enable_r |-> step_cnt_r <= WDT_STEP_LAST)
        else $error("counter step overdue");

    AST_PRESC_HOLD: assert property (@(posedge clk) disable iff (any_rst) // R5
        !enable_r |-> (presc_r == WDT_PRESC_RST && div6_r == WDT_DIV6_RST))
        else $error("prescaler ran while disabled");

    AST_SYS_ONE: assert property (@(posedge clk) disable iff (rst) // R3
        sys_reset_r |=> !sys_reset_r)
        else $error("internal reset longer than one cycle");
    AST_SYS_CLEARS: assert property (@(posedge clk) disable iff (rst) // R13
        sys_reset_r |=> (!enable_r && !load_en_r && count_r == WDT_COUNT_RST
                         && presc_r == WDT_PRESC_RST && !idle_mode_r && !power_down_r))
        else $error("internal reset left state behind");

    // 36 clocks of pin pulse, then release
    AST_PIN_END: assert property (@(posedge clk) disable iff (rst) // R4
        overflow |-> ##36 reset_pin_low_r ##1 !reset_pin_low_r)
        else $error("pin pulse length wrong");

    AST_WAIT_ONE: assert property (@(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");
    AST_WAIT_BACK: assert property (@(posedge clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");

    AST_RDATA_PDOWN: assert property (@(posedge clk) disable iff (any_rst) // R10
        (avs_read && !avs_waitrequest && avs_address == WDT_ADDR_POWER_CONTROL && enable_r)
        |-> !avs_readdata[WDT_PC_PDOWN_BIT])
        else $error("power-down bit read as one while enabled");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (any_rst)
        (avs_read && !avs_waitrequest && avs_address != WDT_ADDR_POWER_CONTROL
         && avs_address != WDT_ADDR_RELOAD_COUNT && avs_address != WDT_ADDR_AUX_CONTROL)
        |-> avs_readdata == WDT_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    AST_IDLE_FOLLOWS: assert property (@(posedge clk) disable iff (any_rst) // R9
        wr_pc |=> idle_mode_r == $past(avs_writedata[WDT_PC_IDLE_BIT]))
        else $error("idle bit not written");

    COV_RELOAD: cover property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == WDT_ADDR_RELOAD_COUNT && load_en_r);
    COV_OVERFLOW: cover property (@(posedge clk) disable iff (rst) overflow);
    COV_PDOWN_TRY: cover property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == WDT_ADDR_POWER_CONTROL && avs_writedata[1] && enable_r);
    COV_PIN_DONE: cover property (@(posedge clk) disable iff (rst)
        reset_pin_low_r ##1 !reset_pin_low_r);
    COV_IDLE_TICK: cover property (@(posedge clk) disable iff (rst) idle_mode_r && tick_count);
endmodule

//--- test_wdt_timer_unit.sv
`timescale 1ns/1ps
module test_wdt_timer_unit;
    import wdt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sys_reset_r;
    logic reset_pin_low_r;
    logic idle_mode_r;
    logic power_down_r;
    int errors = 0;
    int tests_run = 0;
    int m_rc = 0;
    int n;
    logic [15:0] seed = 16'h02DB;
    logic [31:0] q;

    always #5 clk = ~clk;

    wdt_timer_unit wdt_timer_unit_inst
    (
        .clk(clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .sys_reset_r(sys_reset_r),
        .reset_pin_low_r(reset_pin_low_r),
        .idle_mode_r(idle_mode_r),
        .power_down_r(power_down_r)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; one idle edge at the end keeps strobes clean
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 50)
        begin
            errors++;
            $display("[ERR] %0t bus request never answered", $time);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    task automatic final_report;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (80000) @(posedge clk);
        errors++;
        final_report;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(WDT_ADDR_POWER_CONTROL, 32'h0);
        rd(WDT_ADDR_RELOAD_COUNT, 32'h0);
        rd(WDT_ADDR_AUX_CONTROL, 32'h0);
        rd(10'h000, WDT_UNMAPPED_DATA);
        seed = lfsr_next(seed);
        bus(1'b1, WDT_ADDR_RELOAD_COUNT, seed[7:0]);
        rd(WDT_ADDR_RELOAD_COUNT, 32'(m_rc));
        bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h10);
        seed = lfsr_next(seed);
        m_rc = int'(seed[7:0]);
        bus(1'b1, WDT_ADDR_RELOAD_COUNT, seed[7:0]);
        rd(WDT_ADDR_RELOAD_COUNT, 32'(m_rc));
        rd(WDT_ADDR_POWER_CONTROL, 32'h0);
        seed = lfsr_next(seed);
        bus(1'b1, WDT_ADDR_RELOAD_COUNT, seed[7:0]);
        rd(WDT_ADDR_RELOAD_COUNT, 32'(m_rc));
        bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h02);
        chk({31'h0, power_down_r}, 32'h1);
        bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h00);
        bus(1'b1, WDT_ADDR_AUX_CONTROL, 8'h10);
        bus(1'b1, WDT_ADDR_AUX_CONTROL, 8'h00);
        rd(WDT_ADDR_AUX_CONTROL, 32'h10);
        bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h03);
        rd(WDT_ADDR_POWER_CONTROL, 32'h01);
        chk({31'h0, power_down_r}, 32'h0);
        chk({31'h0, idle_mode_r}, 32'h1);
        // shortest interval: one count step must end in overflow even while idle
        bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h11);
        bus(1'b1, WDT_ADDR_RELOAD_COUNT, 8'hFF);
        n = 0;
        while (sys_reset_r !== 1'b1 && n < 12400)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, sys_reset_r}, 32'h1);
        @(negedge clk);
        chk({31'h0, sys_reset_r}, 32'h0);
        n = 1;
        while (reset_pin_low_r === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk(32'(n), 32'(WDT_PIN_PULSE_CYC));
        @(posedge clk);
        rd(WDT_ADDR_AUX_CONTROL, 32'h0);
        rd(WDT_ADDR_POWER_CONTROL, 32'h0);
        rd(WDT_ADDR_RELOAD_COUNT, 32'h0);
        // timely reloads: counter never reaches overflow
        bus(1'b1, WDT_ADDR_AUX_CONTROL, 8'h10);
        n = 0;
        repeat (3)
        begin
            bus(1'b1, WDT_ADDR_POWER_CONTROL, 8'h10);
            bus(1'b1, WDT_ADDR_RELOAD_COUNT, 8'hFE);
            repeat (10000)
            begin
                @(posedge clk);
                if (sys_reset_r !== 1'b0)
                    n++;
            end
        end
        chk(32'(n), 32'h0);
        final_report;
    end
endmodule
